// >>> src/dual_timer_pkg.sv
// ============================================================================
// dual_timer_pkg
// ============================================================================
// Shared constants and types for the dual timer/counter and its edge detector.
// Assumes the port three input bus is eight bits wide and arrives unsynchronised.
package dual_timer_pkg;

  // ==========================================================================
  // widths and pin positions
  // ==========================================================================
  localparam int unsigned PORT_W       = 8;
  localparam int unsigned NUM_TIMERS   = 2;
  localparam int unsigned PIN_GATE0    = 2;  // gate input of the first timer
  localparam int unsigned PIN_GATE1    = 3;  // gate input of the second timer
  localparam int unsigned PIN_COUNT0   = 4;  // first_count_input
  localparam int unsigned PIN_COUNT1   = 5;  // second_count_input

  // ==========================================================================
  // operating modes
  // ==========================================================================
  localparam logic [1:0] MODE_13BIT    = 2'h0;
  localparam logic [1:0] MODE_16BIT    = 2'h1;
  localparam logic [1:0] MODE_RELOAD8  = 2'h2;
  localparam logic [1:0] MODE_SPLIT8   = 2'h3;

  // ==========================================================================
  // reset values and timing
  // ==========================================================================
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic        FLAG_RST     = 1'b0;
  localparam int unsigned CLK_MHZ      = 250;  // one machine cycle per clock
  localparam int unsigned CYCLE_CLKS   = 1;    // clocks per machine cycle
  localparam int unsigned TICK_DIV_DEF = 12;   // slow timer source divide ratio
  localparam int unsigned DIV_W        = 8;
  localparam int unsigned RST_STAGES   = 2;

  // per-timer control word
  typedef struct packed {
    logic       run;      // run control
    logic       gate;     // gate by external signal
    logic       counter;  // count pin falling edges instead of ticks
    logic [1:0] mode;     // operating mode
  } timer_ctrl_t;

  // software load of one byte of a counting register
  typedef struct packed {
    logic       en;
    logic       sel;      // 0 first timer, 1 second timer
    logic       high;     // 1 high byte, 0 low byte
    logic [7:0] data;
  } count_wr_t;

endpackage

// >>> src/pin_fall_detect.sv
// ============================================================================
// pin_fall_detect
// ============================================================================
// Two-stage synchroniser and falling-edge detector for a group of pins.
// Assumes the pins are asynchronous to mclk_i and srst_i is synchronous.
`timescale 1ns/100ps
module pin_fall_detect #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] prev_next;
  logic [WIDTH-1:0] fall_reg;
  logic [WIDTH-1:0] fall_next;

  // ==========================================================================
  // next values: sync chain, then a 1 to 0 compare on the second stage
  // ==========================================================================
  always_comb begin
    meta_next = pin_i;
    sync_next = meta_reg;   // first stage read only here
    prev_next = sync_reg;
    fall_next = prev_reg & ~sync_reg;
    if (srst_i) begin
      meta_next = '1;
      sync_next = '1;
      prev_next = '1;
      fall_next = '0;
    end
  end

  // registers only, reset handled synchronously above
  always_ff @(posedge mclk_i) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
    prev_reg <= prev_next;
    fall_reg <= fall_next;
  end

  assign level_o = sync_reg;
  assign fall_o  = fall_reg;

endmodule

// >>> src/dual_timer_counter.sv
// ============================================================================
// dual_timer_counter
// ============================================================================
// Two 16-bit timer/counters with 13-bit, 16-bit, 8-bit reload and split modes.
// Assumes control words and byte loads come from logic on mclk_i, while the
// port three input bus comes from pins and is synchronised here.
//
// Behaviour
// - two timers, four modes, split mode first only
// - reload mode refills low byte from high
// - counter mode counts count-pin falling edges
// - count pins come from port three bus
// - gating lets external signal hold the count
// - rising edge, synchronous reset, no tri-states
// - one machine cycle equals one clock
// - clock select and internal reset in control
`timescale 1ns/100ps
module dual_timer_counter
  import dual_timer_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_DIV_DEF
) (
  input  wire logic                    mclk_i,
  input  wire logic                    resetn_i,
  input  wire logic [PORT_W-1:0]       port_three_input_bus_i,
  input  timer_ctrl_t [NUM_TIMERS-1:0] ctrl_i,
  input  wire logic                    clk_sel_i,
  input  count_wr_t                    count_wr_i,
  input  wire logic [NUM_TIMERS-1:0]   flag_clr_i,
  output logic [NUM_TIMERS-1:0][15:0]  count_o,
  output logic [NUM_TIMERS-1:0]        ovf_flag_o
);

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = {DIV_W{1'b0}};

  // ==========================================================================
  // internal synchronous reset
  // ==========================================================================
  logic [RST_STAGES-1:0] rst_sync_reg;
  logic [RST_STAGES-1:0] rst_sync_next;
  logic                  srst;

  // shift ones in after release; only the last stage is used
  always_comb begin
    rst_sync_next = {rst_sync_reg[RST_STAGES-2:0], 1'b1};
  end

  // async assertion to a constant, release passes two flops
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= {RST_STAGES{1'b0}};
    end else begin
      rst_sync_reg <= rst_sync_next;
    end
  end

  assign srst = ~rst_sync_reg[RST_STAGES-1];

  // ==========================================================================
  // timer clock source
  // ==========================================================================
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic             slow_tick_reg;
  logic             slow_tick_next;
  logic             base_tick;

  // divider for the slow source, one-cycle enable at each wrap
  always_comb begin
    div_next       = div_reg + DIV_W'(1);
    slow_tick_next = 1'b0;
    if (div_reg == DIV_LAST) begin
      div_next       = DIV_ZERO;
      slow_tick_next = 1'b1;
    end
    if (srst) begin
      div_next       = DIV_ZERO;
      slow_tick_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    div_reg       <= div_next;
    slow_tick_reg <= slow_tick_next;
  end

  // every clock is a machine cycle unless the slow source is chosen
  assign base_tick = clk_sel_i ? slow_tick_reg : 1'b1;

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic [3:0] pins;
  logic [3:0] pin_level;
  logic [3:0] pin_fall;

  // pick count and gate pins out of the port three bus
  assign pins = {port_three_input_bus_i[PIN_GATE1],
                 port_three_input_bus_i[PIN_GATE0],
                 port_three_input_bus_i[PIN_COUNT1],
                 port_three_input_bus_i[PIN_COUNT0]};

  pin_fall_detect #(
    .WIDTH (4)
  ) u_pins (
    .mclk_i  (mclk_i),
    .srst_i  (srst),
    .pin_i   (pins),
    .level_o (pin_level),
    .fall_o  (pin_fall)
  );

  // ==========================================================================
  // per-timer count enable
  // ==========================================================================
  logic [NUM_TIMERS-1:0] allow;
  logic [NUM_TIMERS-1:0] inc;

  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g = g + 1) begin : g_enable
      // run, and gate off or gate pin high
      assign allow[g] = ctrl_i[g].run &
                        (~ctrl_i[g].gate | pin_level[g + 2]);
      // edge in counter mode, machine-cycle tick in timer mode
      assign inc[g]   = allow[g] &
                        (ctrl_i[g].counter ? pin_fall[g] : base_tick);
    end
  endgenerate

  // ==========================================================================
  // counting registers and overflow flags
  // ==========================================================================
  logic [NUM_TIMERS-1:0][15:0] count_reg;
  logic [NUM_TIMERS-1:0][15:0] count_next;
  logic [NUM_TIMERS-1:0]       flag_reg;
  logic [NUM_TIMERS-1:0]       flag_next;

  // mode arithmetic, byte loads, then flag update with set over clear
  always_comb begin
    logic [NUM_TIMERS-1:0] ovf;
    logic [13:0]           sum13;
    logic [16:0]           sum16;
    logic [8:0]            sum8;
    logic                  split;
    ovf        = '0;
    sum13      = '0;
    sum16      = '0;
    sum8       = '0;
    count_next = count_reg;
    split      = (ctrl_i[0].mode == MODE_SPLIT8);
    for (int i = 0; i < NUM_TIMERS; i++) begin
      unique case (ctrl_i[i].mode)
        MODE_13BIT: begin
          sum13 = {1'b0, count_reg[i][15:8], count_reg[i][4:0]} + 14'h0001;
          if (inc[i]) begin
            count_next[i][15:8] = sum13[12:5];
            count_next[i][4:0]  = sum13[4:0];
            ovf[i]              = sum13[13];
          end
        end
        MODE_16BIT: begin
          sum16 = {1'b0, count_reg[i]} + 17'h00001;
          if (inc[i]) begin
            count_next[i] = sum16[15:0];
            ovf[i]        = sum16[16];
          end
        end
        MODE_RELOAD8: begin
          sum8 = {1'b0, count_reg[i][7:0]} + 9'h001;
          if (inc[i]) begin
            ovf[i] = sum8[8];
            // refill from the preset high byte on wrap
            count_next[i][7:0] = sum8[8] ? count_reg[i][15:8] : sum8[7:0];
          end
        end
        MODE_SPLIT8: begin
          if (i == 0) begin
            sum8 = {1'b0, count_reg[0][7:0]} + 9'h001;
            if (inc[0]) begin
              count_next[0][7:0] = sum8[7:0];
              ovf[0]             = sum8[8];
            end
          end
          // the second timer holds in this mode
        end
      endcase
    end
    // split mode: high byte of first timer runs on second run control
    if (split) begin
      sum8 = {1'b0, count_reg[0][15:8]} + 9'h001;
      // second timer flag belongs to the high byte while split
      ovf[1] = 1'b0;
      if (ctrl_i[1].run && base_tick) begin
        count_next[0][15:8] = sum8[7:0];
        ovf[1]              = sum8[8];
      end
    end
    // software byte load takes precedence over counting
    if (count_wr_i.en) begin
      if (count_wr_i.high) begin
        count_next[count_wr_i.sel][15:8] = count_wr_i.data;
      end else begin
        count_next[count_wr_i.sel][7:0] = count_wr_i.data;
      end
    end
    // set wins over a clear in the same cycle
    flag_next = (flag_reg & ~flag_clr_i) | ovf;
    if (srst) begin
      count_next = {NUM_TIMERS{COUNT_RST}};
      flag_next  = {NUM_TIMERS{FLAG_RST}};
    end
  end

  // registers only, synchronous reset computed above
  always_ff @(posedge mclk_i) begin
    count_reg <= count_next;
    flag_reg  <= flag_next;
  end

  assign count_o    = count_reg;
  assign ovf_flag_o = flag_reg;

endmodule

// >>> tb/pulse_source.sv
// ====================
// pulse_source
// ====================
// Model of the outside world on the port three pins: gate levels and count pulses.
// Assumes the caller runs at the falling edge of mclk_i.
`timescale 1ns/100ps
module pulse_source (
  input  wire logic       mclk_i,
  output logic      [7:0] pins_o
);
  // unused pins rest at the pull-up level
  initial pins_o = 8'hFF;

  // set one pin level at once
  task automatic set_pin(input int idx, input logic val);
    pins_o[idx] = val;
  endtask

  // n falling edges, low 2 cycles then high 8 cycles
  task automatic falls(input int idx, input int n);
    repeat (n) begin
      set_pin(idx, 1'b0);
      repeat (2) @(negedge mclk_i);
      set_pin(idx, 1'b1);
      repeat (8) @(negedge mclk_i);
    end
  endtask
endmodule

// >>> tb/dual_timer_counter_sva.sv
// ====================
// dual_timer_counter_sva
// ====================
// Port-level checks of the dual timer/counter.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module dual_timer_counter_sva
  import dual_timer_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_DIV_DEF
) (
  input  wire logic                         mclk_i,
  input  wire logic                         resetn_i,
  input  wire logic [PORT_W-1:0]            port_three_input_bus_i,
  input  timer_ctrl_t [NUM_TIMERS-1:0]      ctrl_i,
  input  wire logic                         clk_sel_i,
  input  count_wr_t                         count_wr_i,
  input  wire logic [NUM_TIMERS-1:0]        flag_clr_i,
  input  wire logic [NUM_TIMERS-1:0][15:0]  count_o,
  input  wire logic [NUM_TIMERS-1:0]        ovf_flag_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // timers ticking every clock or timer 0 counting pin edges, no byte load
  logic free0;
  logic free1;
  logic cnt0;
  assign free0 = ctrl_i[0].run && !ctrl_i[0].gate && !ctrl_i[0].counter && !clk_sel_i
                 && !count_wr_i.en;
  assign free1 = ctrl_i[1].run && !ctrl_i[1].gate && !ctrl_i[1].counter && !clk_sel_i
                 && !count_wr_i.en && ctrl_i[0].mode != MODE_SPLIT8;
  assign cnt0 = ctrl_i[0].run && ctrl_i[0].counter && !ctrl_i[0].gate && !count_wr_i.en
                && ctrl_i[0].mode == MODE_16BIT;

  // one clean pin pulse, then quiet; or the first timer's gate pin held low
  sequence s_fall0;
    $fell(port_three_input_bus_i[PIN_COUNT0]) && cnt0;
  endsequence
  sequence s_quiet0;
    (cnt0 && !port_three_input_bus_i[PIN_COUNT0]) ##1
    (cnt0 && port_three_input_bus_i[PIN_COUNT0])[*7];
  endsequence
  sequence s_gate_low;
    (ctrl_i[0].gate && !port_three_input_bus_i[PIN_GATE0] && !count_wr_i.en
     && ctrl_i[0].mode != MODE_SPLIT8)[*4];
  endsequence

  a_run_off_hold: assert property (
    !ctrl_i[0].run && !count_wr_i.en && ctrl_i[0].mode != MODE_SPLIT8
    |=> $stable(count_o[0])) else $error("timer 0 moved while stopped");
  a_tick_step: assert property (
    free0 && ctrl_i[0].mode == MODE_16BIT |=> count_o[0] == $past(count_o[0]) + 16'h0001)
    else $error("timer 0 did not step once per clock");
  a_wrap_sixteen: assert property (
    free0 && ctrl_i[0].mode == MODE_16BIT && count_o[0] == 16'hFFFF
    |=> count_o[0] == 16'h0000 && ovf_flag_o[0]) else $error("16-bit wrap wrong");
  a_reload_wrap: assert property (
    free1 && ctrl_i[1].mode == MODE_RELOAD8 && count_o[1][7:0] == 8'hFF
    |=> count_o[1][7:0] == $past(count_o[1][15:8]) && ovf_flag_o[1])
    else $error("reload wrap wrong");
  a_wrap_thirteen: assert property (
    free0 && ctrl_i[0].mode == MODE_13BIT && count_o[0][15:8] == 8'hFF
    && count_o[0][4:0] == 5'h1F |=> count_o[0][15:8] == 8'h00 && count_o[0][4:0] == 5'h00
    && ovf_flag_o[0]) else $error("13-bit wrap wrong");
  a_split_hold: assert property (
    ctrl_i[1].mode == MODE_SPLIT8 && !count_wr_i.en |=> $stable(count_o[1]))
    else $error("timer 1 moved in split mode");
  a_flag_clear: assert property (
    flag_clr_i[0] && !ctrl_i[0].run |=> !ovf_flag_o[0]) else $error("flag not cleared");
  a_gate_hold: assert property (
    s_gate_low |=> $stable(count_o[0])) else $error("gated timer moved");
  a_pin_fall: assert property (
    s_fall0 ##1 s_quiet0 |-> count_o[0] == $past(count_o[0], 9) + 16'h0001)
    else $error("pin fall not counted once");
endmodule

// >>> tb/dual_timer_counter_bench.sv
// ====================
// dual_timer_counter_bench
// ====================
// Self-checking bench for the dual timer/counter.
// Assumes the pulse source model drives every port three pin.
`timescale 1ns/100ps
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module dual_timer_counter_bench;
  import dual_timer_pkg::*;
  localparam int unsigned DIV = 2;
  logic                        mclk_i = 1'b0;
  logic                        resetn_i = 1'b0;
  logic [PORT_W-1:0]           pins;
  timer_ctrl_t [NUM_TIMERS-1:0] ctrl = '0;
  logic                        clk_sel = 1'b0;
  count_wr_t                   wr = '0;
  logic [NUM_TIMERS-1:0]       clr = '0;
  logic [NUM_TIMERS-1:0][15:0] count;
  logic [NUM_TIMERS-1:0]       flag;
  int                          fail_count = 0;
  int                          comparisons = 0;

  always #2 mclk_i = ~mclk_i;

  pulse_source i_pulse_source (.mclk_i(mclk_i), .pins_o(pins));
  dual_timer_counter #(.TICK_DIV(DIV)) i_dual_timer_counter (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .port_three_input_bus_i(pins), .ctrl_i(ctrl),
    .clk_sel_i(clk_sel), .count_wr_i(wr), .flag_clr_i(clr), .count_o(count),
    .ovf_flag_o(flag));

  // ====================
  // helpers
  // ====================
  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic load16(input logic sel, input logic [15:0] v);
    wr = '{1'b1, sel, 1'b1, v[15:8]};
    step(1);
    wr = '{1'b1, sel, 1'b0, v[7:0]};
    step(1);
    wr = '0;
    step(1);
  endtask
  task automatic setc(input int t, input logic run, gate, cnt, input logic [1:0] mode);
    ctrl[t] = '{run, gate, cnt, mode};
  endtask
  task automatic clear_flags;
    clr = 2'h3;
    step(1);
    clr = 2'h0;
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ====================
  // scenarios
  // ====================
  task automatic t_wrap16;
    load16(1'b0, 16'hFFFE);
    setc(0, 1, 0, 0, MODE_16BIT);
    step(3);
    ctrl = '0;
    `CHECK("wrap16 count", 16'h0001, count[0])
    `CHECK("wrap16 flag", 1'b1, flag[0])
    clear_flags();
    `CHECK("flag clear", 1'b0, flag[0])
  endtask
  task automatic t_reload;
    load16(1'b1, 16'hF0FE);
    setc(1, 1, 0, 0, MODE_RELOAD8);
    step(4);
    ctrl = '0;
    `CHECK("reload count", 16'hF0F2, count[1])
    `CHECK("reload flag", 1'b1, flag[1])
  endtask
  task automatic t_mode13;
    load16(1'b0, 16'hFFFE);
    setc(0, 1, 0, 0, MODE_13BIT);
    step(2);
    ctrl = '0;
    `CHECK("mode13 count", 16'h00E0, count[0])
    `CHECK("mode13 flag", 1'b1, flag[0])
  endtask
  task automatic t_split;
    clear_flags();
    load16(1'b0, 16'hFF10);
    setc(0, 1, 0, 0, MODE_SPLIT8);
    setc(1, 1, 0, 0, MODE_SPLIT8);
    step(2);
    ctrl = '0;
    `CHECK("split count0", 16'h0112, count[0])
    `CHECK("split count1", 16'hF0F2, count[1])
    `CHECK("split flag1", 1'b1, flag[1])
    `CHECK("split flag0", 1'b0, flag[0])
  endtask
  task automatic t_counter;
    load16(1'b0, 16'h0000);
    load16(1'b1, 16'h0000);
    setc(0, 1, 0, 1, MODE_16BIT);
    setc(1, 1, 0, 1, MODE_16BIT);
    i_pulse_source.falls(PIN_COUNT0, 3);
    i_pulse_source.falls(PIN_COUNT1, 2);
    ctrl = '0;
    `CHECK("pin count0", 16'h0003, count[0])
    `CHECK("pin count1", 16'h0002, count[1])
  endtask
  // first timer measures a gate pulse, second timer stays held by its low gate
  task automatic t_gate;
    load16(1'b0, 16'h0000);
    i_pulse_source.set_pin(PIN_GATE1, 1'b0);
    load16(1'b1, 16'h0000);
    i_pulse_source.set_pin(PIN_GATE0, 1'b0);
    step(4);
    setc(0, 1, 1, 0, MODE_16BIT);
    setc(1, 1, 1, 0, MODE_16BIT);
    step(10);
    `CHECK("gate low", 16'h0000, count[0])
    i_pulse_source.set_pin(PIN_GATE0, 1'b1);
    step(7);
    i_pulse_source.set_pin(PIN_GATE0, 1'b0);
    step(6);
    ctrl = '0;
    `CHECK("gate width", 16'h0007, count[0])
    `CHECK("gate1 low", 16'h0000, count[1])
  endtask
  task automatic t_slow;
    load16(1'b0, 16'h0000);
    clk_sel = 1'b1;
    setc(0, 1, 0, 0, MODE_16BIT);
    step(20);
    ctrl = '0;
    clk_sel = 1'b0;
    `CHECK("slow tick", 16'(20 / DIV), count[0])
  endtask
  // reset after a run, with the timer stopped, clears counts and flags, then counting resumes
  task automatic t_reset;
    load16(1'b1, 16'h5A5A);
    load16(1'b0, 16'hFFFF);
    setc(0, 1, 0, 0, MODE_16BIT);
    step(2);
    ctrl = '0;
    resetn_i = 1'b0;
    step(2);
    `CHECK("reset count0", COUNT_RST, count[0])
    `CHECK("reset count1", COUNT_RST, count[1])
    `CHECK("reset flags", {NUM_TIMERS{FLAG_RST}}, flag)
    resetn_i = 1'b1;
    step(3);
    setc(0, 1, 0, 0, MODE_16BIT);
    step(4);
    ctrl = '0;
    `CHECK("restart count", 16'h0004, count[0])
  endtask

  // main sequence
  initial begin
    step(10);
    resetn_i = 1'b1;
    step(3);
    t_wrap16();
    t_reload();
    t_mode13();
    t_split();
    t_counter();
    t_gate();
    t_slow();
    t_reset();
    print_verdict();
  end

  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge mclk_i);
    fail_count++;
    print_verdict();
  end
endmodule

bind dual_timer_counter dual_timer_counter_sva #(.TICK_DIV(TICK_DIV)) i_dual_timer_counter_sva (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .port_three_input_bus_i(port_three_input_bus_i),
  .ctrl_i(ctrl_i), .clk_sel_i(clk_sel_i), .count_wr_i(count_wr_i), .flag_clr_i(flag_clr_i),
  .count_o(count_o), .ovf_flag_o(ovf_flag_o));
